// *** src/fill_err_pkg.sv ***
package fill_err_pkg;

  // Register byte offsets on the APB map.
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_BUS_ADDR = 8'h04;
  localparam logic [7:0] OFS_FILL_ADDR = 8'h08;
  localparam logic [7:0] OFS_CHECK = 8'h0C;
  localparam logic [7:0] OFS_PROBE = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_CACHE_STAT = 8'h1C;

  // Bus-side status bits, bus_error_status [7:0].
  localparam int ST_SOFT = 0;
  localparam int ST_HARD = 1;
  localparam int ST_TPERR = 2;
  localparam int ST_TCPERR = 3;
  localparam int ST_CMD_LO = 4;
  localparam int ST_BUS_LOST = 7;
  localparam int BUS_ST_W = 8;

  // Fill-side status bits, held locally and shown at bus_error_status [14:8].
  localparam int ST_FILL_LO = 8;
  localparam int FS_ECC = 0;
  localparam int FS_UNC = 1;
  localparam int FS_INSTR = 2;
  localparam int FS_CRD = 3;
  localparam int FS_QW_LO = 4;
  localparam int FS_LOST = 6;
  localparam int FILL_ST_W = 7;

  // Write-one bits of bus_error_status that unlock each register set.
  localparam int UNLOCK_BUS_BIT = 0;
  localparam int UNLOCK_FILL_BIT = 1;

  // memory_unit_control, interrupt_enable_register and cache status bits.
  localparam int CTRL_CORR_EN = 0;
  localparam int CTRL_MC_EN = 1;
  localparam int CTRL_W = 2;
  localparam int IER_UNMASK = 0;
  localparam int CS_DC = 0;
  localparam int CS_IC = 1;
  localparam int CS_W = 2;

  // Field widths.
  localparam int ADDR_W = 34;
  localparam int SYND_W = 14;
  localparam int LW_W = 2;
  localparam int PROBE_W = 16;
  localparam int REQ_W = 3;

  // Acknowledge codes that end a transaction in error.
  localparam logic [2:0] ACK_SOFT = 3'h5;
  localparam logic [2:0] ACK_HARD = 3'h6;

  // Reset values.
  localparam logic [31:0] WORD_RESET = 32'h0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  // Class of error seen on one fill quadword.
  typedef enum logic [1:0] {FILL_NONE, FILL_SINGLE, FILL_DOUBLE, FILL_PARITY} fillKind_t;

endpackage

// *** src/fill_bus_error_logger.sv ***
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module fill_bus_error_logger (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fillValid,
  input wire fill_err_pkg::fillKind_t fillKind,
  input wire logic fillIsInstr,
  input wire logic fillTxnStart,
  input wire logic [1:0] fillQwIndex,
  input wire logic [fill_err_pkg::ADDR_W-1:0] fillAddr,
  input wire logic [2:0] loadPa,
  input wire logic [fill_err_pkg::SYND_W-1:0] fillSyndrome,
  input wire logic [fill_err_pkg::LW_W-1:0] fillBadLongwords,
  input wire logic extCacheEnabled,
  input wire logic [fill_err_pkg::PROBE_W-1:0] probeResult,
  input wire logic tagAddrParityErr,
  input wire logic tagCtlParityErr,
  input wire logic ackValid,
  input wire logic [2:0] cycleAckCode,
  input wire logic [fill_err_pkg::REQ_W-1:0] cycleRequestCode,
  input wire logic [fill_err_pkg::ADDR_W-1:0] busAddr,
  input wire logic dcacheParityErr,
  input wire logic icacheParityErr,
  output logic correctedReadIrq,
  output logic machineCheck,
  output logic icacheFlush,
  output logic dcacheInvalidate,
  output logic fillCorrect,
  output logic fillStoreValidate,
  output logic tagForceMiss
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  logic [fill_err_pkg::BUS_ST_W-1:0] busStat_q;
  logic [fill_err_pkg::FILL_ST_W-1:0] fillStat_q;
  logic busLocked_q;
  logic fillLocked_q;
  logic [31:0] busAddr_q;
  logic [31:0] fillAddr_q;
  logic [fill_err_pkg::SYND_W-1:0] check_q;
  logic [fill_err_pkg::PROBE_W-1:0] probe_q;
  logic [fill_err_pkg::CTRL_W-1:0] ctrl_q;
  logic ier_q;
  logic [fill_err_pkg::CS_W-1:0] cacheStat_q;
  logic qwSeen_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic crd_q;
  logic mchk_q;
  logic flush_q;
  logic dinv_q;
  logic correct_q;
  logic storeVal_q;
  logic forceMiss_q;

  // Decode of one register offset; used only for the error answer, since the read mux decodes its own case.
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == fill_err_pkg::OFS_STATUS) || (a == fill_err_pkg::OFS_BUS_ADDR) ||
               (a == fill_err_pkg::OFS_FILL_ADDR) || (a == fill_err_pkg::OFS_CHECK) ||
               (a == fill_err_pkg::OFS_PROBE) || (a == fill_err_pkg::OFS_CTRL) ||
               (a == fill_err_pkg::OFS_IRQ_EN) || (a == fill_err_pkg::OFS_CACHE_STAT);
  endfunction

  // Write strobe for one offset, taken only at the completing access edge.
  function automatic logic wrHit(input logic acc, input logic [7:0] a, input logic [7:0] ofs);
    wrHit = acc && (a == ofs);
  endfunction

  logic apbAccess;
  logic apbWrite;
  logic unlockBus;
  logic unlockFill;
  logic busOpen;
  logic fillOpen;
  logic ackSoft;
  logic ackHard;
  logic tagErr;
  logic busErr;
  logic busFatal;
  logic fillSingle;
  logic fillUnc;
  logic fillErr;
  logic secondQw;
  logic crdCause;
  logic mchkCause;

  // Event classification; each register set counts as open when unlocked or unlocked this cycle.
  assign apbAccess = psel && penable && pready_q;
  assign apbWrite = apbAccess && pwrite;
  assign unlockBus = wrHit(apbWrite, paddr, fill_err_pkg::OFS_STATUS) && pwdata[fill_err_pkg::UNLOCK_BUS_BIT];
  assign unlockFill = wrHit(apbWrite, paddr, fill_err_pkg::OFS_STATUS) && pwdata[fill_err_pkg::UNLOCK_FILL_BIT];
  assign busOpen = !busLocked_q || unlockBus;
  assign fillOpen = !fillLocked_q || unlockFill;
  assign ackSoft = ackValid && (cycleAckCode == fill_err_pkg::ACK_SOFT);
  assign ackHard = ackValid && (cycleAckCode == fill_err_pkg::ACK_HARD);
  assign tagErr = tagAddrParityErr || tagCtlParityErr;
  assign busErr = ackSoft || ackHard || tagErr;
  assign busFatal = ackHard || tagErr;
  assign fillSingle = fillValid && (fillKind == fill_err_pkg::FILL_SINGLE);
  assign fillUnc = fillValid && ((fillKind == fill_err_pkg::FILL_DOUBLE) || (fillKind == fill_err_pkg::FILL_PARITY));
  assign fillErr = fillSingle || fillUnc;
  assign secondQw = fillSingle && fillIsInstr && qwSeen_q && !fillTxnStart;
  assign crdCause = fillSingle || ackSoft;
  assign mchkCause = secondQw || fillUnc || busFatal || dcacheParityErr || icacheParityErr;

  // Tracks a corrected quadword inside the current instruction fill; a new transaction restarts it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      qwSeen_q <= 1'b0;
    end else if (fillTxnStart) begin
      qwSeen_q <= fillSingle && fillIsInstr;
    end else if (fillSingle && fillIsInstr) begin
      qwSeen_q <= 1'b1;
    end
  end

  // Bus-side set. A new error beats an unlock in the same cycle, so nothing is lost then.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busStat_q <= '0;
      busLocked_q <= 1'b0;
      busAddr_q <= fill_err_pkg::WORD_RESET;
    end else if (busErr && busOpen) begin
      busStat_q[fill_err_pkg::ST_SOFT] <= ackSoft;
      busStat_q[fill_err_pkg::ST_HARD] <= ackHard;
      busStat_q[fill_err_pkg::ST_TPERR] <= tagAddrParityErr;
      busStat_q[fill_err_pkg::ST_TCPERR] <= tagCtlParityErr;
      busStat_q[fill_err_pkg::ST_CMD_LO +: fill_err_pkg::REQ_W] <= ackValid ? cycleRequestCode : '0;
      busStat_q[fill_err_pkg::ST_BUS_LOST] <= 1'b0;
      busAddr_q <= busAddr[fill_err_pkg::ADDR_W-1:2];
      busLocked_q <= 1'b1;
    end else if (busFatal && !busOpen) begin
      busStat_q[fill_err_pkg::ST_BUS_LOST] <= 1'b1;
    end else if (unlockBus) begin
      busStat_q <= '0;
      busLocked_q <= 1'b0;
    end
  end

  // Fill-side set, independent of the bus side.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fillStat_q <= '0;
      fillLocked_q <= 1'b0;
      fillAddr_q <= fill_err_pkg::WORD_RESET;
      check_q <= '0;
    end else if (fillErr && fillOpen) begin
      fillStat_q[fill_err_pkg::FS_ECC] <= fillKind != fill_err_pkg::FILL_PARITY;
      fillStat_q[fill_err_pkg::FS_CRD] <= fillSingle;
      fillStat_q[fill_err_pkg::FS_UNC] <= fillUnc;
      fillStat_q[fill_err_pkg::FS_INSTR] <= fillIsInstr;
      fillStat_q[fill_err_pkg::FS_QW_LO +: 2] <= fillQwIndex;
      fillStat_q[fill_err_pkg::FS_LOST] <= 1'b0;
      fillAddr_q <= {fillAddr[fill_err_pkg::ADDR_W-1:5], fillIsInstr ? 3'h0 : loadPa};
      check_q <= fillSingle ? fillSyndrome : {{(fill_err_pkg::SYND_W-fill_err_pkg::LW_W){1'b0}}, fillBadLongwords};
      fillLocked_q <= 1'b1;
    end else if (fillUnc && !fillOpen) begin
      fillStat_q[fill_err_pkg::FS_LOST] <= 1'b1;
    end else if (unlockFill) begin
      fillStat_q <= '0;
      fillLocked_q <= 1'b0;
    end
  end

  // Probe result is shared; either set may load it only while that set is open.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      probe_q <= '0;
    end else if (tagErr && busOpen) begin
      probe_q <= probeResult;
    end else if (fillErr && fillOpen && extCacheEnabled) begin
      probe_q <= probeResult;
    end
  end

  // Control, enable and cache status registers; a parity event beats a clearing write.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= fill_err_pkg::CTRL_RESET;
      ier_q <= 1'b0;
      cacheStat_q <= '0;
    end else begin
      if (wrHit(apbWrite, paddr, fill_err_pkg::OFS_CTRL)) begin
        ctrl_q <= pwdata[fill_err_pkg::CTRL_W-1:0];
      end
      if (wrHit(apbWrite, paddr, fill_err_pkg::OFS_IRQ_EN)) begin
        ier_q <= pwdata[fill_err_pkg::IER_UNMASK];
      end
      cacheStat_q[fill_err_pkg::CS_DC] <= dcacheParityErr || (cacheStat_q[fill_err_pkg::CS_DC] &&
        !(wrHit(apbWrite, paddr, fill_err_pkg::OFS_CACHE_STAT) && pwdata[fill_err_pkg::CS_DC]));
      cacheStat_q[fill_err_pkg::CS_IC] <= icacheParityErr || (cacheStat_q[fill_err_pkg::CS_IC] &&
        !(wrHit(apbWrite, paddr, fill_err_pkg::OFS_CACHE_STAT) && pwdata[fill_err_pkg::CS_IC]));
    end
  end

  // Reporting pulses; they depend on enables only, never on the lock state.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      crd_q <= 1'b0;
      mchk_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      crd_q <= crdCause && ctrl_q[fill_err_pkg::CTRL_CORR_EN] && ier_q;
      mchk_q <= mchkCause && ctrl_q[fill_err_pkg::CTRL_MC_EN];
      flush_q <= mchkCause && ctrl_q[fill_err_pkg::CTRL_MC_EN];
    end
  end

  // Cache-side actions for the fill and probe paths.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dinv_q <= 1'b0;
      correct_q <= 1'b0;
      storeVal_q <= 1'b0;
      forceMiss_q <= 1'b0;
    end else begin
      dinv_q <= fillValid && !fillIsInstr &&
        ((fillKind == fill_err_pkg::FILL_SINGLE) || (fillKind == fill_err_pkg::FILL_DOUBLE));
      correct_q <= fillSingle && !secondQw;
      storeVal_q <= (fillKind == fill_err_pkg::FILL_PARITY && fillValid) ||
        (fillKind == fill_err_pkg::FILL_DOUBLE && fillValid && fillIsInstr);
      forceMiss_q <= tagErr;
    end
  end

  // APB slave: one wait state, then a registered answer; unmapped offsets give pslverr.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= fill_err_pkg::WORD_RESET;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !isMapped(paddr);
      prdata_q <= fill_err_pkg::WORD_RESET;
      if (psel && penable && !pready_q && !pwrite) begin
        unique case (paddr)
          fill_err_pkg::OFS_STATUS: prdata_q <= {17'h0, fillStat_q, busStat_q};
          fill_err_pkg::OFS_BUS_ADDR: prdata_q <= busAddr_q;
          fill_err_pkg::OFS_FILL_ADDR: prdata_q <= fillAddr_q;
          fill_err_pkg::OFS_CHECK: prdata_q <= {18'h0, check_q};
          fill_err_pkg::OFS_PROBE: prdata_q <= {16'h0, probe_q};
          fill_err_pkg::OFS_CTRL: prdata_q <= {30'h0, ctrl_q};
          fill_err_pkg::OFS_IRQ_EN: prdata_q <= {31'h0, ier_q};
          fill_err_pkg::OFS_CACHE_STAT: prdata_q <= {30'h0, cacheStat_q};
          default: prdata_q <= fill_err_pkg::WORD_RESET;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign correctedReadIrq = crd_q;
  assign machineCheck = mchk_q;
  assign icacheFlush = flush_q;
  assign dcacheInvalidate = dinv_q;
  assign fillCorrect = correct_q;
  assign fillStoreValidate = storeVal_q;
  assign tagForceMiss = forceMiss_q;

  // Checks kept beside the logic they guard.
  property p_singleFlags;
    fillSingle && fillIsInstr && fillOpen |=> fillStat_q[fill_err_pkg::FS_ECC] &&
      fillStat_q[fill_err_pkg::FS_INSTR] && fillStat_q[fill_err_pkg::FS_CRD] && fillLocked_q;
  endproperty
  a_singleFlags: assert property (p_singleFlags) else $error("single-bit fill flags wrong");

  property p_secondQw;
    secondQw && ctrl_q[fill_err_pkg::CTRL_MC_EN] |=> machineCheck && icacheFlush && !fillCorrect;
  endproperty
  a_secondQw: assert property (p_secondQw) else $error("second quadword missed machine check");

  property p_dataInval;
    fillSingle && !fillIsInstr |=> dcacheInvalidate ##1 !dcacheInvalidate || $past(fillValid);
  endproperty
  a_dataInval: assert property (p_dataInval) else $error("data cache not invalidated");

  property p_loadPa;
    fillErr && !fillIsInstr && fillOpen |=> fillAddr_q[2:0] == $past(loadPa);
  endproperty
  a_loadPa: assert property (p_loadPa) else $error("load address bits not stored");

  property p_tagMiss;
    tagAddrParityErr |=> tagForceMiss && busLocked_q;
  endproperty
  a_tagMiss: assert property (p_tagMiss) else $error("tag parity did not force miss");

  property p_softAck;
    ackSoft && busOpen |=> busStat_q[fill_err_pkg::ST_SOFT] &&
      busStat_q[fill_err_pkg::ST_CMD_LO +: fill_err_pkg::REQ_W] == $past(cycleRequestCode);
  endproperty
  a_softAck: assert property (p_softAck) else $error("soft acknowledge not recorded");

  property p_lockHold;
    busLocked_q && !unlockBus |=> $stable(busAddr_q) [*2] or unlockBus || !busLocked_q;
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("locked bus address changed");

  property p_softNoLost;
    ackSoft && !busOpen && !busFatal |=> $stable(busStat_q[fill_err_pkg::ST_BUS_LOST]);
  endproperty
  a_softNoLost: assert property (p_softNoLost) else $error("soft error touched lost flag");

  property p_fillLost;
    fillUnc && !fillOpen |=> fillStat_q[fill_err_pkg::FS_LOST] && $stable(fillAddr_q);
  endproperty
  a_fillLost: assert property (p_fillLost) else $error("lost fill error not flagged");

  property p_crdGate;
    correctedReadIrq |-> $past(ctrl_q[fill_err_pkg::CTRL_CORR_EN]) && $past(ier_q) && $past(crdCause);
  endproperty
  a_crdGate: assert property (p_crdGate) else $error("interrupt without both enables");

endmodule // fill_bus_error_logger

// *** verification/sys_ctrl_model.sv ***
`timescale 1ns/100ps
// Far side of the block: system logic returning fill quadwords and acknowledge codes,
// plus the external cache tag store whose probe may fail parity.
module sys_ctrl_model (
  input wire logic mclk,
  output logic fillValid,
  output fill_err_pkg::fillKind_t fillKind,
  output logic fillIsInstr,
  output logic fillTxnStart,
  output logic [1:0] fillQwIndex,
  output logic [fill_err_pkg::ADDR_W-1:0] fillAddr,
  output logic [2:0] loadPa,
  output logic [fill_err_pkg::SYND_W-1:0] fillSyndrome,
  output logic [fill_err_pkg::LW_W-1:0] fillBadLongwords,
  output logic extCacheEnabled,
  output logic [fill_err_pkg::PROBE_W-1:0] probeResult,
  output logic tagAddrParityErr,
  output logic tagCtlParityErr,
  output logic ackValid,
  output logic [2:0] cycleAckCode,
  output logic [fill_err_pkg::REQ_W-1:0] cycleRequestCode,
  output logic [fill_err_pkg::ADDR_W-1:0] busAddr
);
  // Released lines carry junk, so a late sample sees wrong data rather than stale data.
  task automatic idle(input logic [33:0] a, input logic [15:0] pr);
    fillTxnStart <= 1'b0;
    fillValid <= 1'b0;
    fillKind <= fill_err_pkg::FILL_NONE;
    fillIsInstr <= a[0];
    fillQwIndex <= a[1:0];
    fillAddr <= a;
    loadPa <= a[4:2];
    fillSyndrome <= a[13:0];
    fillBadLongwords <= a[3:2];
    extCacheEnabled <= 1'b0;
    probeResult <= pr;
    tagAddrParityErr <= 1'b0;
    tagCtlParityErr <= 1'b0;
    ackValid <= 1'b0;
    cycleAckCode <= a[2:0];
    cycleRequestCode <= a[5:3];
    busAddr <= a;
  endtask

  // Quiet at time zero.
  initial begin
    idle(34'h2_AAAA_5555, 16'h5A5A);
  end

  // An optional transaction start, then one errored quadword held for the edge that samples it.
  task automatic sendFill(input logic st, input fill_err_pkg::fillKind_t k, input logic ins,
      input logic [1:0] qw, input logic [33:0] a, input logic [2:0] pa, input logic [13:0] syn,
      input logic [1:0] lw, input logic ec, input logic [15:0] pr);
    @(posedge mclk);
    fillTxnStart <= st;
    @(posedge mclk);
    fillTxnStart <= 1'b0;
    fillValid <= 1'b1;
    fillKind <= k;
    fillIsInstr <= ins;
    fillQwIndex <= qw;
    fillAddr <= a;
    loadPa <= pa;
    fillSyndrome <= syn;
    fillBadLongwords <= lw;
    extCacheEnabled <= ec;
    probeResult <= pr;
    @(posedge mclk);
    idle(~a, ~pr);
  endtask

  // A bus event: an acknowledge ending a cycle and/or a failed tag probe.
  task automatic busEvent(input logic ack, input logic [2:0] code, input logic [2:0] req,
      input logic [1:0] tag, input logic [33:0] a, input logic [15:0] pr);
    @(posedge mclk);
    ackValid <= ack;
    cycleAckCode <= code;
    cycleRequestCode <= req;
    tagAddrParityErr <= tag[0];
    tagCtlParityErr <= tag[1];
    busAddr <= a;
    probeResult <= pr;
    @(posedge mclk);
    idle(~a, ~pr);
  endtask
endmodule // sys_ctrl_model

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
// Self-checking bench: APB master, far-side model and one task per scenario.
module tb_top;
  localparam logic [7:0] ST = fill_err_pkg::OFS_STATUS;
  localparam logic [7:0] CS = fill_err_pkg::OFS_CACHE_STAT;
  localparam fill_err_pkg::fillKind_t K1 = fill_err_pkg::FILL_SINGLE;
  localparam logic [33:0] FA = 34'h2_468A_CE74;
  localparam logic [33:0] BA = 34'h1_1357_9BDC;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [1:0] cacheErr = 2'h0;
  logic pready, pslverr, fillValid, fillIsInstr, fillTxnStart, extCacheEnabled, ackValid;
  logic tagAddrParityErr, tagCtlParityErr, irq, mchk, flush, dinv, fixQw, storeVal, forceMiss;
  fill_err_pkg::fillKind_t fillKind;
  logic [1:0] fillQwIndex, fillBadLongwords;
  logic [2:0] loadPa, cycleAckCode, cycleRequestCode;
  logic [13:0] fillSyndrome;
  logic [15:0] probeResult;
  logic [33:0] fillAddr, busAddr;
  logic [6:0] pulses;
  logic irqOn = 1'b0;
  logic mchkOn = 1'b0;
  int mismatches = 0;
  int numChecks = 0;
  // Event outputs gathered in one vector for comparison.
  assign pulses = {irq, mchk, flush, dinv, fixQw, storeVal, forceMiss};

  // 50 MHz clock.
  always #10 mclk = ~mclk;

  fill_bus_error_logger u_dut (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fillValid(fillValid),
    .fillKind(fillKind), .fillIsInstr(fillIsInstr), .fillTxnStart(fillTxnStart), .fillQwIndex(fillQwIndex),
    .fillAddr(fillAddr), .loadPa(loadPa), .fillSyndrome(fillSyndrome), .fillBadLongwords(fillBadLongwords),
    .extCacheEnabled(extCacheEnabled), .probeResult(probeResult), .tagAddrParityErr(tagAddrParityErr),
    .tagCtlParityErr(tagCtlParityErr), .ackValid(ackValid), .cycleAckCode(cycleAckCode),
    .cycleRequestCode(cycleRequestCode), .busAddr(busAddr), .dcacheParityErr(cacheErr[0]),
    .icacheParityErr(cacheErr[1]), .correctedReadIrq(irq), .machineCheck(mchk), .icacheFlush(flush),
    .dcacheInvalidate(dinv), .fillCorrect(fixQw), .fillStoreValidate(storeVal), .tagForceMiss(forceMiss));

  sys_ctrl_model u_sys (
    .mclk(mclk), .fillValid(fillValid), .fillKind(fillKind), .fillIsInstr(fillIsInstr),
    .fillTxnStart(fillTxnStart), .fillQwIndex(fillQwIndex), .fillAddr(fillAddr), .loadPa(loadPa),
    .fillSyndrome(fillSyndrome), .fillBadLongwords(fillBadLongwords), .extCacheEnabled(extCacheEnabled),
    .probeResult(probeResult), .tagAddrParityErr(tagAddrParityErr), .tagCtlParityErr(tagCtlParityErr),
    .ackValid(ackValid), .cycleAckCode(cycleAckCode), .cycleRequestCode(cycleRequestCode), .busAddr(busAddr));

  // Prints the verdict and ends the run.
  task automatic giveVerdict();
    if (mismatches == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Word comparison.
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Event pulse comparison, made in the one cycle the pulses stand.
  task automatic chkPulses(input logic [6:0] exp, input string what);
    numChecks++;
    if (pulses !== exp) begin
      mismatches++;
      $display("ERROR %0t %s pulses %b expected %b", $time, what, pulses, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("ERROR %0t no pready", $time);
      giveVerdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chkWord(q, exp, what);
  endtask

  // Sets both enable registers and remembers what the expectations must assume.
  task automatic setEn(input logic [1:0] ctl, input logic ier);
    wr(fill_err_pkg::OFS_CTRL, {30'h0, ctl});
    wr(fill_err_pkg::OFS_IRQ_EN, {31'h0, ier});
    irqOn = ctl[fill_err_pkg::CTRL_CORR_EN] & ier;
    mchkOn = ctl[fill_err_pkg::CTRL_MC_EN];
  endtask

  task automatic resetValues();
    logic [31:0] q;
    logic e;
    rdChk(ST, 32'h0, "status reset");
    rdChk(fill_err_pkg::OFS_CTRL, 32'h0, "control reset");
    apb(1'b0, 8'h40, 32'h0, q, e);
    chkWord({q[30:0], e}, 32'h1, "unmapped read");
  endtask

  // Each fill class in each stream, on a free fill set, with every captured field checked.
  task automatic fillTable();
    fill_err_pkg::fillKind_t k;
    logic ins, one, par;
    logic [6:0] exp;
    setEn(2'h3, 1'b1);
    for (int i = 0; i < 6; i++) begin
      k = fill_err_pkg::fillKind_t'(2'(i / 2 + 1));
      ins = i[0];
      one = (k == K1);
      par = (k == fill_err_pkg::FILL_PARITY);
      exp = {one & irqOn, !one & mchkOn, !one & mchkOn, !ins & !par, one, par | (!one & ins), 1'b0};
      wr(ST, 32'h2);
      u_sys.sendFill(1'b1, k, ins, 2'(i), FA, 3'h5, 14'h2A7, 2'h2, i != 5, 16'hA500 + 16'(i));
      #1;
      chkPulses(exp, "fill");
      rdChk(ST, {17'h0, 1'b0, 2'(i), one, ins, !one, !par, 8'h00}, "fill status");
      rdChk(fill_err_pkg::OFS_FILL_ADDR, {FA[33:5], ins ? 3'h0 : 3'h5}, "fill addr");
      rdChk(fill_err_pkg::OFS_CHECK, one ? 32'h2A7 : 32'h2, "check");
      rdChk(fill_err_pkg::OFS_PROBE, 32'hA500 + 32'(i == 5 ? 4 : i), "probe");
    end
  endtask

  // Later fills while the fill set is locked.
  task automatic lockedFill();
    wr(ST, 32'h2);
    u_sys.sendFill(1'b1, K1, 1'b1, 2'h1, FA, 3'h2, 14'h155, 2'h1, 1'b1, 16'h0F0F);
    #1;
    chkPulses(7'b1000100, "first qw");
    u_sys.sendFill(1'b0, K1, 1'b1, 2'h2, ~FA, 3'h1, 14'h0AA, 2'h2, 1'b1, 16'h7070);
    #1;
    chkPulses(7'b1110000, "second qw");
    u_sys.sendFill(1'b1, K1, 1'b0, 2'h3, ~FA, 3'h6, 14'h0AA, 2'h2, 1'b1, 16'h7070);
    #1;
    chkPulses(7'b1001100, "locked single");
    rdChk(ST, 32'h1D00, "locked status");
    u_sys.sendFill(1'b1, fill_err_pkg::FILL_DOUBLE, 1'b0, 2'h0, ~FA, 3'h6, 14'h0AA, 2'h2, 1'b1, 16'h7070);
    #1;
    chkPulses(7'b0111000, "locked double");
    rdChk(ST, 32'h5D00, "fill lost");
    rdChk(fill_err_pkg::OFS_FILL_ADDR, {FA[33:5], 3'h0}, "locked addr");
  endtask

  // Acknowledge codes and tag parity on the bus set, with enables varied.
  task automatic busCases();
    wr(ST, 32'h3);
    setEn(2'h3, 1'b0);
    u_sys.busEvent(1'b1, fill_err_pkg::ACK_SOFT, 3'h4, 2'h0, BA, 16'h1234);
    #1;
    chkPulses(7'b0, "soft masked");
    rdChk(ST, 32'h41, "soft status");
    rdChk(fill_err_pkg::OFS_BUS_ADDR, BA[33:2], "bus addr");
    setEn(2'h1, 1'b1);
    u_sys.busEvent(1'b1, fill_err_pkg::ACK_SOFT, 3'h2, 2'h0, ~BA, 16'h1234);
    #1;
    chkPulses(7'b1000000, "soft locked");
    u_sys.busEvent(1'b1, fill_err_pkg::ACK_HARD, 3'h6, 2'h0, ~BA, 16'h1234);
    #1;
    chkPulses(7'b0, "hard disabled");
    rdChk(ST, 32'hC1, "bus lost");
    setEn(2'h3, 1'b1);
    wr(ST, 32'h1);
    u_sys.busEvent(1'b1, fill_err_pkg::ACK_HARD, 3'h3, 2'h0, BA, 16'h1234);
    #1;
    chkPulses(7'b0110000, "hard");
    rdChk(ST, 32'h32, "hard status");
    wr(ST, 32'h1);
    u_sys.busEvent(1'b0, 3'h0, 3'h0, 2'h2, BA, 16'hC3C3);
    #1;
    chkPulses(7'b0110001, "tag ctl");
    rdChk(fill_err_pkg::OFS_PROBE, 32'hC3C3, "tag probe");
    u_sys.busEvent(1'b0, 3'h0, 3'h0, 2'h1, ~BA, 16'h3C3C);
    #1;
    chkPulses(7'b0110001, "tag addr");
    rdChk(ST, 32'h88, "tag status");
  endtask

  // Primary cache parity pulses driven by the bench.
  task automatic cacheParity();
    for (int i = 1; i < 3; i++) begin
      @(posedge mclk);
      cacheErr <= 2'(i);
      @(posedge mclk);
      cacheErr <= 2'h0;
      #1;
      chkPulses(7'b0110000, "cache parity");
      rdChk(CS, 32'(i), "cache status");
      wr(CS, 32'h3);
    end
  endtask

  // Reset for two cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    resetValues();
    fillTable();
    lockedFill();
    busCases();
    cacheParity();
    giveVerdict();
  end
endmodule // tb_top
